// file: hdl/swdcu_defs.svh
// Constants for the single-wire debug command unit: offsets, fields, reset values, timing
`ifndef SWDCU_DEFS_SVH
`define SWDCU_DEFS_SVH
`define SWDCU_OFS_CSR 4'h0
`define SWDCU_OFS_CMD 4'h4
`define SWDCU_CSR_EN 15
`define SWDCU_CSR_BDM 14
`define SWDCU_CSR_WAIT 6
`define SWDCU_CSR_ILL 5
`define SWDCU_CSR_NO_RESPONSE_FLAG 4
`define SWDCU_CSR_OVR 3
`define SWDCU_CSR_ACKEN 2
`define SWDCU_CSR_RST 16'h0000
`define SWDCU_DLY_CYC 8'h10
`define SWDCU_ACK_CYC 8'h20
`define SWDCU_SYNC_GAP 8'h10
`define SWDCU_SYNC_LOW 8'h80
`define SWDCU_SYNC_DET 8'h80
`define SWDCU_OP_NOP 8'h00
`define SWDCU_OP_SYNCPC 8'h01
`define SWDCU_OP_ACKON 8'h02
`define SWDCU_OP_ACKOFF 8'h03
`define SWDCU_OP_BGND 8'h04
`define SWDCU_OP_STEP 8'h09
`define SWDCU_OP_CSRWR 8'h0D
`define SWDCU_OP_CSRRD 8'h2D
`define SWDCU_OP_ERASE 8'h95
`define SWDCU_GRP_WMEM 4'h1
`define SWDCU_GRP_RMEM 4'h3
`define SWDCU_GRP_REGWR 4'h4
`define SWDCU_GRP_SAME 4'h5
`define SWDCU_SZ_BYTE 2'h0
`define SWDCU_SZ_WORD 2'h1
`endif

// file: hdl/swdcu_pkg.sv
// Types for the single-wire debug command unit
package swdcu_pkg;
	typedef enum logic [3:0] {
		st_idle, st_addr, st_wdata, st_exec, st_wait, st_dly, st_stat, st_rdata,
		st_sync_hi, st_sync_gap, st_sync_low, st_sync_pulse
	} swdcu_fsm_type;

	typedef enum logic [3:0] {
		kind_ill, kind_nop, kind_syncpc, kind_ackon, kind_ackoff, kind_bgnd, kind_step,
		kind_csrwr, kind_csrrd, kind_erase, kind_wmem, kind_rmem, kind_dump, kind_same, kind_regwr
	} swdcu_kind_type;

	typedef struct packed {
		logic req;
		logic we;
		logic [1:0] size;
		logic [23:0] addr;
		logic [31:0] wdata;
	} swdcu_mem_type;

	typedef struct packed {
		swdcu_fsm_type st;
		swdcu_kind_type kind;
		logic [7:0] cmd;
		logic [7:0] cnt;
		logic [7:0] lowc;
		logic [2:0] idx;
		logic [23:0] addr;
		logic [23:0] rd_addr;
		logic [23:0] seq_addr;
		logic [31:0] data;
		logic ack_en;
		logic en;
		logic ovr;
		logic ill;
		logic no_response_flag;
		logic seq_ok;
		logic tx_valid;
		logic [7:0] tx_byte;
		logic ack_pulse;
		logic pin_oe;
		logic pin_out;
		swdcu_mem_type mem;
		logic reg_wr;
		logic halt;
		logic step;
		logic erase;
		logic [31:0] bus_rdata;
	} swdcu_state_type;
endpackage

// file: hdl/swdcu_core.sv
// Command decoder and executor of the single-wire debug controller
`timescale 1ns/1ns
`include "swdcu_defs.svh"

// Operation
// - Reread returns same address data, acknowledged
// - Reread with status: delay, status, data
// - Status register read always, no acknowledge
// - Memory write: address, data, write, acknowledge
// - Memory write with status: delay, status
// - Core register write only when halted
// - Status register write always, no acknowledge
// - Mass erase always, fixed delay, no acknowledge
// - Single step only halted, then acknowledge
// - Sync response: gap, 128 low, pulse
// - Sync response clears overrun flag
// - After sync next edge starts fresh
// - Handshake off: later commands unacknowledged
// - Handshake on: acknowledge later commands, itself
// - Halt request only when debug enabled
// - Halt in wait sets no-response flag
// - Sequential read advances address by size
// - Sequential read status first or acknowledge
// - Sequential read legal only after listed commands
// - Size field: byte, word, long, reserved long
// - Fixed delay slot is 16 cycles
// - Acknowledge slot 16 plain or 32 then pulse
// - Memory read sets the later read address
module swdcu_core (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic debug_pin_in,
	output logic debug_pin_out,
	output logic debug_pin_oe,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	output logic tx_valid,
	output logic [7:0] tx_byte,
	input wire logic tx_ready,
	output logic ack_pulse,
	output swdcu_pkg::swdcu_mem_type mem,
	input wire logic mem_done,
	input wire logic [31:0] mem_rdata,
	output logic core_reg_wr,
	output logic [3:0] core_reg_num,
	output logic [31:0] core_reg_data,
	output logic halt_req,
	output logic step_req,
	input wire logic step_done,
	output logic erase_start,
	input wire logic cpu_halted,
	input wire logic cpu_wait,
	input wire logic [23:0] pc_value,
	input wire logic [3:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata
);
	swdcu_pkg::swdcu_state_type s;
	swdcu_pkg::swdcu_state_type next_s;
	logic [15:0] csr;
	logic [2:0] nb;
	logic is_read;
	logic with_status;
	logic fixed_slot;
	logic acked;

	function automatic logic [2:0] size_bytes(input logic [1:0] sz);
		if (sz == `SWDCU_SZ_BYTE) begin
			size_bytes = 3'h1;
		end else if (sz == `SWDCU_SZ_WORD) begin
			size_bytes = 3'h2;
		end else begin
			size_bytes = 3'h4;
		end
	endfunction

	function automatic swdcu_pkg::swdcu_kind_type classify(input logic [7:0] op);
		classify = swdcu_pkg::kind_ill;
		if (op == `SWDCU_OP_NOP) classify = swdcu_pkg::kind_nop;
		else if (op == `SWDCU_OP_SYNCPC) classify = swdcu_pkg::kind_syncpc;
		else if (op == `SWDCU_OP_ACKON) classify = swdcu_pkg::kind_ackon;
		else if (op == `SWDCU_OP_ACKOFF) classify = swdcu_pkg::kind_ackoff;
		else if (op == `SWDCU_OP_BGND) classify = swdcu_pkg::kind_bgnd;
		else if (op == `SWDCU_OP_STEP) classify = swdcu_pkg::kind_step;
		else if (op == `SWDCU_OP_CSRWR) classify = swdcu_pkg::kind_csrwr;
		else if (op == `SWDCU_OP_CSRRD) classify = swdcu_pkg::kind_csrrd;
		else if (op == `SWDCU_OP_ERASE) classify = swdcu_pkg::kind_erase;
		else if (op[7:4] == `SWDCU_GRP_WMEM && !op[1]) classify = swdcu_pkg::kind_wmem;
		else if (op[7:4] == `SWDCU_GRP_RMEM && !op[1]) classify = swdcu_pkg::kind_rmem;
		else if (op[7:4] == `SWDCU_GRP_RMEM && op[1]) classify = swdcu_pkg::kind_dump;
		else if (op[7:4] == `SWDCU_GRP_SAME && !op[1]) classify = swdcu_pkg::kind_same;
		else if (op[7:4] == `SWDCU_GRP_REGWR) classify = swdcu_pkg::kind_regwr;
	endfunction

	always_comb begin
		csr = `SWDCU_CSR_RST;
		csr[`SWDCU_CSR_EN] = s.en;
		csr[`SWDCU_CSR_BDM] = cpu_halted;
		csr[`SWDCU_CSR_WAIT] = cpu_wait;
		csr[`SWDCU_CSR_ILL] = s.ill;
		csr[`SWDCU_CSR_NO_RESPONSE_FLAG] = s.no_response_flag;
		csr[`SWDCU_CSR_OVR] = s.ovr;
		csr[`SWDCU_CSR_ACKEN] = s.ack_en;
	end

	always_comb begin
		nb = size_bytes(s.cmd[3:2]);
		with_status = (s.kind == swdcu_pkg::kind_wmem || s.kind == swdcu_pkg::kind_rmem ||
			s.kind == swdcu_pkg::kind_dump || s.kind == swdcu_pkg::kind_same) && s.cmd[0];
		is_read = s.kind == swdcu_pkg::kind_rmem || s.kind == swdcu_pkg::kind_dump ||
			s.kind == swdcu_pkg::kind_same || s.kind == swdcu_pkg::kind_syncpc;
		fixed_slot = with_status || s.kind == swdcu_pkg::kind_ackoff || s.kind == swdcu_pkg::kind_erase;
		acked = !fixed_slot && s.ack_en;
	end

	always_comb begin
		next_s = s;
		next_s.ack_pulse = 1'b0;
		next_s.mem.req = 1'b0;
		next_s.reg_wr = 1'b0;
		next_s.halt = 1'b0;
		next_s.step = 1'b0;
		next_s.erase = 1'b0;
		next_s.bus_rdata = 32'h0000_0000;
		if (bus_rd) begin
			if (bus_addr == `SWDCU_OFS_CSR) begin
				next_s.bus_rdata = {16'h0000, csr};
			end else if (bus_addr == `SWDCU_OFS_CMD) begin
				next_s.bus_rdata = {s.seq_addr, s.cmd};
			end
		end
		// Flags are write-one-to-clear; hardware sets below still win in the same cycle
		if (bus_wr && bus_addr == `SWDCU_OFS_CSR) begin
			next_s.en = bus_wdata[`SWDCU_CSR_EN];
			next_s.ack_en = bus_wdata[`SWDCU_CSR_ACKEN];
			if (bus_wdata[`SWDCU_CSR_ILL]) next_s.ill = 1'b0;
			if (bus_wdata[`SWDCU_CSR_NO_RESPONSE_FLAG]) next_s.no_response_flag = 1'b0;
			if (bus_wdata[`SWDCU_CSR_OVR]) next_s.ovr = 1'b0;
		end
		if (cpu_halted) next_s.no_response_flag = 1'b0;
		if (s.cnt != 8'hFF) next_s.cnt = s.cnt + 8'h01;
		case (s.st)
			swdcu_pkg::st_idle: begin
				if (rx_valid) begin
					next_s.cmd = rx_byte;
					next_s.kind = classify(rx_byte);
					next_s.st = swdcu_pkg::st_exec;
					if (classify(rx_byte) == swdcu_pkg::kind_wmem || classify(rx_byte) == swdcu_pkg::kind_rmem) begin
						next_s.st = swdcu_pkg::st_addr;
						next_s.idx = 3'h2;
					end else if (classify(rx_byte) == swdcu_pkg::kind_regwr) begin
						next_s.st = swdcu_pkg::st_wdata;
						next_s.idx = 3'h3;
					end else if (classify(rx_byte) == swdcu_pkg::kind_csrwr) begin
						next_s.st = swdcu_pkg::st_wdata;
						next_s.idx = 3'h1;
					end
				end
			end
			swdcu_pkg::st_addr: begin
				if (rx_valid) begin
					next_s.addr[8*s.idx +: 8] = rx_byte;
					next_s.idx = s.idx - 3'h1;
					if (s.idx == 3'h0) begin
						if (s.kind == swdcu_pkg::kind_wmem) begin
							next_s.st = swdcu_pkg::st_wdata;
							next_s.idx = nb - 3'h1;
							next_s.data = 32'h0000_0000;
						end else begin
							next_s.st = swdcu_pkg::st_exec;
						end
					end
				end
			end
			swdcu_pkg::st_wdata: begin
				if (rx_valid) begin
					next_s.data[8*s.idx +: 8] = rx_byte;
					next_s.idx = s.idx - 3'h1;
					if (s.idx == 3'h0) next_s.st = swdcu_pkg::st_exec;
				end
			end
			swdcu_pkg::st_exec: begin
				next_s.cnt = 8'h00;
				next_s.st = swdcu_pkg::st_dly;
				next_s.seq_ok = 1'b0;
				if (s.kind == swdcu_pkg::kind_ill || (s.kind == swdcu_pkg::kind_dump && !s.seq_ok) ||
					((s.kind == swdcu_pkg::kind_regwr || s.kind == swdcu_pkg::kind_step) && !cpu_halted)) begin
					next_s.ill = 1'b1;
					next_s.st = swdcu_pkg::st_idle;
				end else begin
					case (s.kind)
						swdcu_pkg::kind_nop: begin
							next_s.seq_ok = 1'b1;
						end
						swdcu_pkg::kind_syncpc: begin
							next_s.data = {8'h00, pc_value};
						end
						swdcu_pkg::kind_ackon: begin
							next_s.ack_en = 1'b1;
						end
						swdcu_pkg::kind_ackoff: begin
							next_s.ack_en = 1'b0;
						end
						swdcu_pkg::kind_bgnd: begin
							// Disabled request is dropped silently, the slot still runs
							if (s.en) next_s.halt = 1'b1;
							if (s.en && cpu_wait && !cpu_halted) next_s.no_response_flag = 1'b1;
						end
						swdcu_pkg::kind_step: begin
							next_s.step = 1'b1;
							next_s.st = swdcu_pkg::st_wait;
						end
						swdcu_pkg::kind_csrwr: begin
							next_s.en = s.data[`SWDCU_CSR_EN];
							next_s.ack_en = s.data[`SWDCU_CSR_ACKEN];
							if (s.data[`SWDCU_CSR_ILL]) next_s.ill = 1'b0;
							if (s.data[`SWDCU_CSR_NO_RESPONSE_FLAG]) next_s.no_response_flag = 1'b0;
							if (s.data[`SWDCU_CSR_OVR]) next_s.ovr = 1'b0;
							next_s.st = swdcu_pkg::st_idle;
						end
						swdcu_pkg::kind_csrrd: begin
							next_s.data = {16'h0000, csr};
							next_s.idx = 3'h1;
							next_s.st = swdcu_pkg::st_rdata;
						end
						swdcu_pkg::kind_erase: begin
							next_s.erase = 1'b1;
						end
						swdcu_pkg::kind_regwr: begin
							next_s.reg_wr = 1'b1;
						end
						default: begin
							next_s.mem.req = 1'b1;
							next_s.mem.we = s.kind == swdcu_pkg::kind_wmem;
							next_s.mem.size = s.cmd[3:2];
							next_s.mem.wdata = s.data;
							next_s.mem.addr = s.addr;
							if (s.kind == swdcu_pkg::kind_dump) next_s.mem.addr = s.seq_addr;
							if (s.kind == swdcu_pkg::kind_same) next_s.mem.addr = s.rd_addr;
							if (s.kind == swdcu_pkg::kind_rmem) next_s.rd_addr = s.addr;
							next_s.seq_ok = s.kind == swdcu_pkg::kind_rmem || s.kind == swdcu_pkg::kind_dump;
							next_s.st = swdcu_pkg::st_wait;
						end
					endcase
				end
			end
			swdcu_pkg::st_wait: begin
				if ((s.kind == swdcu_pkg::kind_step && step_done) || (s.kind != swdcu_pkg::kind_step && mem_done)) begin
					next_s.st = swdcu_pkg::st_dly;
					if (is_read) next_s.data = mem_rdata;
					if (s.kind == swdcu_pkg::kind_rmem) next_s.seq_addr = s.addr + {21'h000000, nb};
					if (s.kind == swdcu_pkg::kind_dump) next_s.seq_addr = s.seq_addr + {21'h000000, nb};
				end
			end
			swdcu_pkg::st_dly: begin
				// The slot is timed from the start of execution, so a slow access eats into it
				if (s.cnt >= (acked ? `SWDCU_ACK_CYC : `SWDCU_DLY_CYC) - 8'h01) begin
					next_s.ack_pulse = acked;
					next_s.idx = (s.kind == swdcu_pkg::kind_syncpc) ? 3'h2 : nb - 3'h1;
					if (with_status) begin
						next_s.st = swdcu_pkg::st_stat;
					end else if (is_read) begin
						next_s.st = swdcu_pkg::st_rdata;
					end else begin
						next_s.st = swdcu_pkg::st_idle;
					end
				end
			end
			swdcu_pkg::st_stat: begin
				if (!s.tx_valid) begin
					next_s.tx_valid = 1'b1;
					next_s.tx_byte = csr[7:0];
				end else if (tx_ready) begin
					next_s.tx_valid = 1'b0;
					next_s.st = is_read ? swdcu_pkg::st_rdata : swdcu_pkg::st_idle;
				end
			end
			swdcu_pkg::st_rdata: begin
				if (!s.tx_valid) begin
					next_s.tx_valid = 1'b1;
					next_s.tx_byte = s.data[8*s.idx +: 8];
				end else if (tx_ready) begin
					next_s.tx_valid = 1'b0;
					next_s.idx = s.idx - 3'h1;
					if (s.idx == 3'h0) next_s.st = swdcu_pkg::st_idle;
				end
			end
			swdcu_pkg::st_sync_hi: begin
				if (debug_pin_in) begin
					next_s.st = swdcu_pkg::st_sync_gap;
					next_s.cnt = 8'h00;
				end
			end
			swdcu_pkg::st_sync_gap: begin
				if (s.cnt == `SWDCU_SYNC_GAP - 8'h01) begin
					next_s.st = swdcu_pkg::st_sync_low;
					next_s.cnt = 8'h00;
					next_s.pin_oe = 1'b1;
					next_s.pin_out = 1'b0;
				end
			end
			swdcu_pkg::st_sync_low: begin
				if (s.cnt == `SWDCU_SYNC_LOW - 8'h01) begin
					next_s.st = swdcu_pkg::st_sync_pulse;
					next_s.pin_out = 1'b1;
				end
			end
			default: begin
				next_s.pin_oe = 1'b0;
				next_s.pin_out = 1'b0;
				next_s.ovr = 1'b0;
				next_s.seq_ok = 1'b1;
				next_s.st = swdcu_pkg::st_idle;
			end
		endcase
		// Bytes arriving while a command executes cannot be honoured
		if (rx_valid && !(s.st == swdcu_pkg::st_idle || s.st == swdcu_pkg::st_addr || s.st == swdcu_pkg::st_wdata))
			next_s.ovr = 1'b1;
		next_s.lowc = 8'h00;
		if (!debug_pin_in && !s.pin_oe && s.lowc != `SWDCU_SYNC_DET) next_s.lowc = s.lowc + 8'h01;
		else if (!debug_pin_in && !s.pin_oe) next_s.lowc = s.lowc;
		// A low far longer than any bit is a sync request; it aborts the command in flight and its memory request, not other pulses raised that cycle
		if (s.lowc == `SWDCU_SYNC_DET - 8'h01 && !debug_pin_in && !s.pin_oe && s.st != swdcu_pkg::st_sync_hi &&
			s.st != swdcu_pkg::st_sync_gap && s.st != swdcu_pkg::st_sync_low && s.st != swdcu_pkg::st_sync_pulse) begin
			next_s.st = swdcu_pkg::st_sync_hi;
			next_s.tx_valid = 1'b0;
			next_s.mem.req = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign debug_pin_out = s.pin_out;
	assign debug_pin_oe = s.pin_oe;
	assign tx_valid = s.tx_valid;
	assign tx_byte = s.tx_byte;
	assign ack_pulse = s.ack_pulse;
	assign mem = s.mem;
	assign core_reg_wr = s.reg_wr;
	assign core_reg_num = s.cmd[3:0];
	assign core_reg_data = s.data;
	assign halt_req = s.halt;
	assign step_req = s.step;
	assign erase_start = s.erase;
	assign bus_rdata = s.bus_rdata;

	logic [7:0] low_run;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			low_run <= 8'h00;
		end else if (s.pin_oe && !s.pin_out) begin
			low_run <= low_run + 8'h01;
		end else begin
			low_run <= 8'h00;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence sync_low_seq;
		s.pin_oe && !s.pin_out && low_run == 8'h7F;
	endsequence
	sequence sync_release_seq;
		!s.pin_oe;
	endsequence
	sync_pulse_a: assert property (sync_low_seq |=> s.pin_oe && s.pin_out ##1 sync_release_seq)
		else $error("sync response low time or pulse wrong");
	ovr_clear_a: assert property (s.st == swdcu_pkg::st_sync_pulse && !rx_valid |=> !s.ovr)
		else $error("overrun not cleared by sync response");
	ack_only_en_a: assert property (ack_pulse |-> $past(s.ack_en) && !$past(fixed_slot))
		else $error("acknowledge without handshake");
	ack_slot_a: assert property (ack_pulse |-> $past(s.cnt) >= 8'h1F)
		else $error("acknowledge slot too short");
	dump_ill_a: assert property (s.st == swdcu_pkg::st_exec && s.kind == swdcu_pkg::kind_dump && !s.seq_ok
		|=> s.ill && !s.mem.req)
		else $error("out of order sequential read accepted");
	reread_addr_a: assert property (s.mem.req && $past(s.kind) == swdcu_pkg::kind_same
		|-> s.mem.addr == s.rd_addr && $stable(s.rd_addr))
		else $error("reread used wrong address");
	halt_en_a: assert property (halt_req |-> $past(s.en))
		else $error("halt requested while debug disabled");
	reg_halted_a: assert property (core_reg_wr |-> $past(cpu_halted))
		else $error("core register written while running");
	step_halted_a: assert property (step_req |-> $past(cpu_halted))
		else $error("step issued while running");
	erase_cmd_a: assert property (erase_start |-> s.cmd == `SWDCU_OP_ERASE ##[15:16] s.st == swdcu_pkg::st_idle)
		else $error("erase slot wrong");
endmodule

// file: sim/swdcu_host.sv
// Far-side model: byte sink of the framer, memory responder and step responder
`timescale 1ns/1ns
module swdcu_host (
	input wire logic clock,
	input wire logic slow,
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	output logic tx_ready,
	input wire swdcu_pkg::swdcu_mem_type mem,
	output logic mem_done,
	output logic [31:0] mem_rdata,
	input wire logic step_req,
	output logic step_done
);
	logic [7:0] got[$];
	swdcu_pkg::swdcu_mem_type last;
	int nreq = 0;
	logic [3:0] wait_cnt = 4'h0;
	logic [1:0] step_cnt = 2'h0;

	initial begin
		tx_ready = 1'b0;
		mem_done = 1'b0;
		mem_rdata = 32'h00000000;
		step_done = 1'b0;
	end

	always @(posedge clock) begin
		// Slow mode drops ready every other cycle so the offer must be held
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_valid && tx_ready)
			got.push_back(tx_byte);
		mem_done <= 1'b0;
		// Stale read data keeps changing so it cannot pass for an answer
		mem_rdata <= ~mem_rdata;
		if (mem.req) begin
			last <= mem;
			nreq <= nreq + 1;
			wait_cnt <= slow ? 4'h9 : 4'h1;
		end else if (wait_cnt == 4'h1) begin
			mem_done <= 1'b1;
			mem_rdata <= {8'hC3, last.addr};
			wait_cnt <= 4'h0;
		end else if (wait_cnt != 4'h0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end
		step_done <= step_cnt == 2'h1;
		if (step_req)
			step_cnt <= 2'h2;
		else if (step_cnt != 2'h0)
			step_cnt <= step_cnt - 2'h1;
	end
endmodule

// file: sim/swdcu_tb.sv
// Self-checking bench for the single-wire debug command unit
`timescale 1ns/1ns
module tb;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic rx_valid = 1'b0;
	logic [7:0] rx_byte = 8'h00;
	logic cpu_halted = 1'b0;
	logic cpu_wait = 1'b0;
	logic [23:0] pc_value = 24'h00ABCD;
	logic [3:0] bus_addr = 4'h0;
	logic [31:0] bus_wdata = 32'h00000000;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic slow = 1'b1;
	logic hdrv = 1'b0;
	logic hval = 1'b1;
	logic pin_out, pin_oe, tx_valid, tx_ready, ack_pulse, mem_done, step_done;
	logic core_reg_wr, halt_req, step_req, erase_start;
	logic [7:0] tx_byte;
	logic [3:0] core_reg_num;
	logic [31:0] mem_rdata, core_reg_data, bus_rdata;
	logic [35:0] reg_cap;
	logic [39:0] rxv;
	swdcu_pkg::swdcu_mem_type mem;
	// Pulled-up wire: host, device or the pull-up
	wire pin = pin_oe ? pin_out : (hdrv ? hval : 1'b1);
	int errors = 0, checks = 0, cyc = 0, acks = 0, ack_at = 0, last_at = 0;
	int halts = 0, steps = 0, erases = 0, regwr = 0, n = 0;
	int tx_at = 0;

	swdcu_core i_swdcu_core (.clock, .rst_b, .debug_pin_in(pin), .debug_pin_out(pin_out),
		.debug_pin_oe(pin_oe), .rx_valid, .rx_byte, .tx_valid, .tx_byte, .tx_ready, .ack_pulse,
		.mem, .mem_done, .mem_rdata, .core_reg_wr, .core_reg_num, .core_reg_data, .halt_req,
		.step_req, .step_done, .erase_start, .cpu_halted, .cpu_wait, .pc_value, .bus_addr,
		.bus_wdata, .bus_wr, .bus_rd, .bus_rdata);
	swdcu_host i_swdcu_host (.clock, .slow, .tx_valid, .tx_byte, .tx_ready, .mem, .mem_done,
		.mem_rdata, .step_req, .step_done);

	always #20 clock = ~clock;

	always @(posedge clock) begin
		cyc <= cyc + 1;
		halts <= halts + int'(halt_req);
		steps <= steps + int'(step_req);
		erases <= erases + int'(erase_start);
		if (ack_pulse) begin
			acks <= acks + 1;
			ack_at <= cyc;
		end
		if (core_reg_wr) begin
			regwr <= regwr + 1;
			reg_cap <= {core_reg_num, core_reg_data};
		end
	end

	task chk(input logic [39:0] seen, input logic [39:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task send(input logic [7:0] b);
		@(posedge clock);
		rx_valid <= 1'b1;
		rx_byte <= b;
		last_at = cyc;
		@(posedge clock);
		rx_valid <= 1'b0;
	endtask

	// Opcode, then nb payload bytes MSB first; collects nexp answer bytes
	task xfer(input logic [7:0] op, input int nb, input logic [55:0] p, input int nexp);
		int w;
		w = 0;
		tx_at = 0;
		i_swdcu_host.got.delete();
		send(op);
		for (int i = nb - 1; i >= 0; i--)
			send(p[i*8 +: 8]);
		while (i_swdcu_host.got.size() < nexp && w < 300) begin
			@(posedge clock);
			// First cycle in which an answer byte is offered
			if (tx_valid && tx_at == 0)
				tx_at = cyc;
			w++;
		end
		// Covers the longest slot, its acknowledge and the halt settling time
		repeat (48) @(posedge clock);
		rxv = 40'h0;
		foreach (i_swdcu_host.got[k])
			rxv = {rxv[31:0], i_swdcu_host.got[k]};
	endtask

	task bread(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clock);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clock);
		bus_rd <= 1'b0;
		#1;
		chk(bus_rdata, exp);
	endtask

	task bwrite(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clock);
		bus_wr <= 1'b0;
	endtask

	// Counts cycles while the pin drive matches m: 00 released, 10 low, 11 high
	task span(input logic [1:0] m, output int c);
		c = 0;
		while ({pin_oe, pin_out & pin_oe} == m && c < 300) begin
			@(posedge clock);
			#1;
			c++;
		end
	endtask

	task test_done;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		test_done();
	end

	initial begin
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		bread(4'h0, 32'h0);
		bwrite(4'h8, 32'hFFFF);
		bread(4'h8, 32'h0);
		bread(4'h0, 32'h0);
		$display("register port done");
		xfer(8'h0D, 2, 56'h8000, 0);
		xfer(8'h2D, 0, 56'h0, 2);
		chk(rxv, 40'h8000);
		xfer(8'h03, 0, 56'h0, 0);
		chk(acks, 0);
		xfer(8'h00, 0, 56'h0, 0);
		chk(acks, 0);
		xfer(8'h02, 0, 56'h0, 0);
		chk(acks, 1);
		chk((ack_at - last_at) inside {[32:40]}, 1);
		$display("handshake done");
		xfer(8'h38, 3, 56'h001230, 4);
		chk(rxv, 40'hC3001230);
		chk(i_swdcu_host.last.addr, 40'h001230);
		xfer(8'h50, 0, 56'h0, 1);
		chk(rxv, 40'h30);
		xfer(8'h55, 0, 56'h0, 3);
		chk(rxv, 40'h041230);
		chk(acks, 3);
		// A reread does not open a sequential run, so a no-op comes first
		xfer(8'h00, 0, 56'h0, 0);
		xfer(8'h36, 0, 56'h0, 2);
		chk(rxv, 40'h1234);
		xfer(8'h32, 0, 56'h0, 1);
		chk(rxv, 40'h36);
		xfer(8'h33, 0, 56'h0, 2);
		chk(rxv, 40'h0437);
		chk(acks, 6);
		bread(4'h4, 32'h00123833);
		$display("memory reads done");
		slow <= 1'b0;
		xfer(8'h14, 5, 56'h002000BEEF, 0);
		chk({i_swdcu_host.last.we, i_swdcu_host.last.size, i_swdcu_host.last.addr}, 27'h5002000);
		chk(i_swdcu_host.last.wdata[15:0], 16'hBEEF);
		xfer(8'h11, 4, 56'h0020015A, 1);
		chk(rxv, 40'h04);
		chk(i_swdcu_host.last.wdata[7:0], 8'h5A);
		chk(acks, 7);
		// Last byte, exec, the 16-cycle slot, then the status byte is offered
		chk(tx_at - last_at, 20);
		xfer(8'h1C, 7, 56'h00200401020304, 0);
		chk(i_swdcu_host.last.wdata, 32'h01020304);
		bread(4'h0, 32'h8004);
		xfer(8'h32, 0, 56'h0, 0);
		chk(i_swdcu_host.got.size(), 0);
		chk(i_swdcu_host.nreq, 9);
		bread(4'h0, 32'h8024);
		chk(acks, 8);
		$display("memory writes done");
		xfer(8'h43, 4, 56'hCAFEF00D, 0);
		xfer(8'h09, 0, 56'h0, 0);
		chk(regwr + steps, 0);
		cpu_halted <= 1'b1;
		xfer(8'h43, 4, 56'hCAFEF00D, 0);
		chk(reg_cap, 36'h3CAFEF00D);
		xfer(8'h09, 0, 56'h0, 0);
		chk(steps, 1);
		chk(acks, 10);
		cpu_halted <= 1'b0;
		xfer(8'h04, 0, 56'h0, 0);
		chk(halts, 1);
		xfer(8'h0D, 2, 56'h0004, 0);
		xfer(8'h04, 0, 56'h0, 0);
		chk(halts, 1);
		xfer(8'h0D, 2, 56'h8004, 0);
		cpu_wait <= 1'b1;
		xfer(8'h04, 0, 56'h0, 0);
		xfer(8'h2D, 0, 56'h0, 2);
		chk(rxv & 40'h4050, 40'h0050);
		xfer(8'h50, 0, 56'h0, 1);
		chk(rxv, 40'h30);
		cpu_wait <= 1'b0;
		$display("processor control done");
		send(8'h95);
		send(8'h00);
		repeat (48) @(posedge clock);
		chk(erases, 1);
		chk(acks, 14);
		xfer(8'h2D, 0, 56'h0, 2);
		chk(rxv & 40'h8, 40'h8);
		hdrv <= 1'b1;
		hval <= 1'b0;
		repeat (140) @(posedge clock);
		hval <= 1'b1;
		@(posedge clock);
		hdrv <= 1'b0;
		span(2'b00, n);
		chk(n inside {[14:19]}, 1);
		span(2'b10, n);
		chk(n, 128);
		span(2'b11, n);
		chk(n, 1);
		chk(pin_oe, 1'b0);
		xfer(8'h2D, 0, 56'h0, 2);
		chk(i_swdcu_host.got.size(), 2);
		chk(rxv & 40'h8, 40'h0);
		xfer(8'h00, 0, 56'h0, 0);
		xfer(8'h32, 0, 56'h0, 1);
		chk(rxv, 40'h38);
		xfer(8'hFF, 0, 56'h0, 0);
		chk(i_swdcu_host.got.size(), 0);
		chk(acks, 16);
		xfer(8'h01, 0, 56'h0, 3);
		chk(rxv, 40'h00ABCD);
		chk(acks, 17);
		$display("erase and resync done");
		test_done();
	end
endmodule
